// ---- src/inductive_sensor_status_regs.sv ----
// register bank and result snapshot of the inductive sensor converter
//
// Behaviour
// - pin function: off, wake, comparator, ready
// - power bit: 0 standby, 1 converting
// - status bit 7 shows oscillator stopped
// - status bit 6 low when fresh data
// - status bit 5 low on wake trigger
// - status bit 4 comparator: below low sets
// - status read-only, bits 3:0 meaningless
// - 8-bit loss result read-only register
// - 24-bit frequency count over three bytes
// - frequency count copied only when loss read starts
// - loss clipped outside floor/ceiling range
// - sample rate is frequency over count/3
// - response code 2..7 gives 192..6144
// - thresholds high 0x07, low 0x09
`timescale 1ns/1ps
`default_nettype none
module inductive_sensor_status_regs #(
  parameter logic [7:0] CEILING_RESET = 8'h00
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // serial pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  // event pin
  output logic             event_pin_n,
  // front end results
  input  wire logic        conv_valid,
  input  wire logic [7:0]  conv_loss,
  input  wire logic        conv_below_floor,
  input  wire logic        conv_above_ceiling,
  input  wire logic [23:0] conv_freq,
  input  wire logic        osc_stopped,
  // front end controls
  output logic             conversion_enable,
  output logic [11:0]      sample_divide,
  output logic [1:0]       amplitude_select,
  output logic [7:0]       loss_range_floor,
  output logic [7:0]       loss_range_ceiling
);
  logic        cmd_valid;
  logic        cmd_read;
  logic [6:0]  cmd_addr;
  logic        wr_valid;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  logic [7:0]  config_reg;
  logic [7:0]  thr_high;
  logic [7:0]  thr_low;
  logic [7:0]  pin_function_select;
  logic [7:0]  power_control;
  logic [7:0]  latest_loss;
  logic [23:0] latest_freq;
  logic [23:0] freq_count;
  logic        fresh;
  logic        comp_state;
  logic        wake_hit;
  logic [7:0]  clipped_loss;
  logic        take_conv;
  logic        loss_read;
  logic [7:0]  device_state_flags;
  logic [2:0]  func;

  // ****************************************************************
  // serial port
  // ****************************************************************
  serial_port u_port (
    .mclk      (mclk),
    .reset     (reset),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .sdi       (sdi),
    .sdo       (sdo),
    .sdo_oe    (sdo_oe),
    .cmd_valid (cmd_valid),
    .cmd_read  (cmd_read),
    .cmd_addr  (cmd_addr),
    .wr_valid  (wr_valid),
    .wr_data   (wr_data),
    .rd_data   (rd_data)
  );

  // ****************************************************************
  // writable registers
  // ****************************************************************
  // one write per data byte; unmapped and read-only offsets ignored
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      loss_range_ceiling  <= CEILING_RESET;
      loss_range_floor    <= sense_regs_pkg::RESET_FLOOR;
      config_reg          <= sense_regs_pkg::RESET_CONFIG;
      thr_high            <= sense_regs_pkg::RESET_THR_HIGH;
      thr_low             <= sense_regs_pkg::RESET_THR_LOW;
      pin_function_select <= sense_regs_pkg::RESET_PIN_FUNC;
      power_control       <= sense_regs_pkg::RESET_POWER;
    end else if (wr_valid) begin
      unique case (cmd_addr)
        sense_regs_pkg::ADDR_CEILING:  loss_range_ceiling  <= wr_data;
        sense_regs_pkg::ADDR_FLOOR:    loss_range_floor    <= wr_data;
        sense_regs_pkg::ADDR_CONFIG:   config_reg          <= {3'h0,
          wr_data[sense_regs_pkg::CFG_MSB:0]};
        sense_regs_pkg::ADDR_THR_HIGH: thr_high            <= wr_data;
        sense_regs_pkg::ADDR_THR_LOW:  thr_low             <= wr_data;
        sense_regs_pkg::ADDR_PIN_FUNC: pin_function_select <= {5'h00,
          wr_data[sense_regs_pkg::FUNC_MSB:0]};
        sense_regs_pkg::ADDR_POWER:    power_control       <= {7'h00,
          wr_data[sense_regs_pkg::POWER_BIT]};
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // front end controls
  // ****************************************************************
  // response code to count/3 of sensor cycles per sample
  function automatic logic [11:0] resp_third(input logic [2:0] code);
    if (code < sense_regs_pkg::RESP_CODE_MIN) begin
      resp_third = sense_regs_pkg::RESP_THIRD_MIN; // reserved codes
    end else begin
      resp_third = sense_regs_pkg::RESP_THIRD_MIN <<
        (code - sense_regs_pkg::RESP_CODE_MIN);
    end
  endfunction

  assign conversion_enable =
    power_control[sense_regs_pkg::POWER_BIT];
  assign sample_divide =
    resp_third(config_reg[sense_regs_pkg::RESP_MSB:0]);
  assign amplitude_select =
    config_reg[sense_regs_pkg::AMP_MSB:sense_regs_pkg::AMP_LSB];

  // ****************************************************************
  // conversion intake
  // ****************************************************************
  // standby ignores results; clip outside the programmed range
  assign take_conv = conv_valid & conversion_enable;
  assign clipped_loss = conv_below_floor ? sense_regs_pkg::LOSS_MIN :
    conv_above_ceiling ? sense_regs_pkg::LOSS_MAX : conv_loss;
  assign loss_read = cmd_valid & cmd_read &
    (cmd_addr == sense_regs_pkg::ADDR_LOSS);
  assign func = pin_function_select[sense_regs_pkg::FUNC_MSB:0];

  // most recent conversion; loss read directly, frequency not yet visible to the host
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      latest_loss <= 8'h00;
      latest_freq <= 24'h00_0000;
    end else if (take_conv) begin
      latest_loss <= clipped_loss;
      latest_freq <= conv_freq;
    end
  end

  // snapshot taken when a loss read begins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      freq_count  <= 24'h00_0000;
    end else if (loss_read) begin
      freq_count  <= latest_freq;
    end
  end

  // fresh data flag; a new conversion wins over the read
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fresh <= 1'b0;
    end else if (take_conv) begin
      fresh <= 1'b1;
    end else if (loss_read) begin
      fresh <= 1'b0;
    end
  end

  // comparator with hysteresis band between thresholds
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      comp_state <= 1'b0;
    end else if (take_conv) begin
      if (clipped_loss < thr_low) begin
        comp_state <= 1'b1;
      end else if (clipped_loss > thr_high) begin
        comp_state <= 1'b0;
      end
    end
  end // between thresholds holds

  // wake trigger held until wake function is left
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wake_hit <= 1'b0;
    end else if (func != sense_regs_pkg::FUNC_WAKE) begin
      wake_hit <= 1'b0;
    end else if (take_conv && clipped_loss > thr_high) begin
      wake_hit <= 1'b1;
    end
  end

  // ****************************************************************
  // status and read data
  // ****************************************************************
  always_comb begin
    device_state_flags = sense_regs_pkg::READ_ZERO;
    device_state_flags[sense_regs_pkg::STAT_OSC]     = osc_stopped;
    device_state_flags[sense_regs_pkg::STAT_READY_N] = ~fresh;
    device_state_flags[sense_regs_pkg::STAT_WAKE_N]  = ~wake_hit;
    device_state_flags[sense_regs_pkg::STAT_COMP]    = comp_state;
  end

  // read byte latched one cycle after the command byte
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else if (cmd_valid) begin
      unique case (cmd_addr)
        sense_regs_pkg::ADDR_CEILING:   rd_data <= loss_range_ceiling;
        sense_regs_pkg::ADDR_FLOOR:     rd_data <= loss_range_floor;
        sense_regs_pkg::ADDR_CONFIG:    rd_data <= config_reg;
        sense_regs_pkg::ADDR_THR_HIGH:  rd_data <= thr_high;
        sense_regs_pkg::ADDR_THR_LOW:   rd_data <= thr_low;
        sense_regs_pkg::ADDR_PIN_FUNC:  rd_data <= pin_function_select;
        sense_regs_pkg::ADDR_POWER:     rd_data <= power_control;
        sense_regs_pkg::ADDR_STATUS:    rd_data <= device_state_flags;
        sense_regs_pkg::ADDR_LOSS:      rd_data <= latest_loss;
        sense_regs_pkg::ADDR_FREQ_LOW:  rd_data <= freq_count[7:0];
        sense_regs_pkg::ADDR_FREQ_MID:  rd_data <= freq_count[15:8];
        sense_regs_pkg::ADDR_FREQ_HIGH: rd_data <= freq_count[23:16];
        default:                        rd_data <= sense_regs_pkg::READ_ZERO;
      endcase
    end
  end

  // ****************************************************************
  // event pin
  // ****************************************************************
  // reserved codes and disabled mode leave the pin high
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      event_pin_n <= 1'b1;
    end else begin
      unique case (func)
        sense_regs_pkg::FUNC_WAKE:  event_pin_n <= ~wake_hit;
        sense_regs_pkg::FUNC_COMP:  event_pin_n <= comp_state;
        sense_regs_pkg::FUNC_READY: event_pin_n <= ~fresh;
        default:                    event_pin_n <= 1'b1;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- src/sense_regs_pkg.sv ----
// constants shared by the inductive sensor register bank
package sense_regs_pkg;
  // register offsets
  localparam logic [6:0] ADDR_CEILING   = 7'h01;
  localparam logic [6:0] ADDR_FLOOR     = 7'h02;
  localparam logic [6:0] ADDR_CONFIG    = 7'h04;
  localparam logic [6:0] ADDR_THR_HIGH  = 7'h07;
  localparam logic [6:0] ADDR_THR_LOW   = 7'h09;
  localparam logic [6:0] ADDR_PIN_FUNC  = 7'h0a;
  localparam logic [6:0] ADDR_POWER     = 7'h0b;
  localparam logic [6:0] ADDR_STATUS    = 7'h20;
  localparam logic [6:0] ADDR_LOSS      = 7'h22;
  localparam logic [6:0] ADDR_FREQ_LOW  = 7'h23;
  localparam logic [6:0] ADDR_FREQ_MID  = 7'h24;
  localparam logic [6:0] ADDR_FREQ_HIGH = 7'h25;
  // reset values
  localparam logic [7:0] RESET_FLOOR    = 8'h14;
  localparam logic [7:0] RESET_CONFIG   = 8'h1b;
  localparam logic [7:0] RESET_THR_HIGH = 8'hff;
  localparam logic [7:0] RESET_THR_LOW  = 8'h00;
  localparam logic [7:0] RESET_PIN_FUNC = 8'h00;
  localparam logic [7:0] RESET_POWER    = 8'h00;
  // field layouts
  localparam int        FUNC_MSB        = 2;
  localparam int        RESP_MSB        = 2;
  localparam int        AMP_LSB         = 3;
  localparam int        AMP_MSB         = 4;
  localparam int        CFG_MSB         = 4;
  localparam int        POWER_BIT       = 0;
  localparam int        STAT_OSC        = 7;
  localparam int        STAT_READY_N    = 6;
  localparam int        STAT_WAKE_N     = 5;
  localparam int        STAT_COMP       = 4;
  // pin function codes
  localparam logic [2:0] FUNC_OFF       = 3'h0;
  localparam logic [2:0] FUNC_WAKE      = 3'h1;
  localparam logic [2:0] FUNC_COMP      = 3'h2;
  localparam logic [2:0] FUNC_READY     = 3'h4;
  // response time: code 2 is 192 counts, one third of it is 64
  localparam logic [2:0]  RESP_CODE_MIN = 3'h2;
  localparam logic [11:0] RESP_THIRD_MIN = 12'h040;
  // loss clip limits
  localparam logic [7:0] LOSS_MIN       = 8'h00;
  localparam logic [7:0] LOSS_MAX       = 8'hff;
  localparam logic [7:0] READ_ZERO      = 8'h00;
  // serial frame: bit 7 of the command byte set means read
  localparam int        CMD_READ_BIT    = 7;
  localparam logic [2:0] LAST_BIT       = 3'h7;
endpackage

// ---- src/serial_port.sv ----
// serial slave: synchronises pins, splits command and data bytes
`timescale 1ns/1ps
`default_nettype none
module serial_port (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // pins from the host
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  // register side
  output logic            cmd_valid,
  output logic            cmd_read,
  output logic [6:0]      cmd_addr,
  output logic            wr_valid,
  output logic [7:0]      wr_data,
  input  wire logic [7:0] rd_data
);
  logic [2:0] sclk_q;
  logic [1:0] cs_q;
  logic [1:0] sdi_q;
  logic       rise;
  logic       fall;
  logic       active;
  logic [2:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic       data_phase;
  logic [7:0] next_byte;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // two stages each; sclk has a third stage for edge detection
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sclk_q <= 3'h0;
      cs_q   <= 2'h3;
      sdi_q  <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk};
      cs_q   <= {cs_q[0], cs_n};
      sdi_q  <= {sdi_q[0], sdi};
    end
  end

  assign active    = ~cs_q[1];
  assign rise      = active & sclk_q[1] & ~sclk_q[2];
  assign fall      = active & ~sclk_q[1] & sclk_q[2];
  assign next_byte = {shift_in[6:0], sdi_q[1]};

  // ****************************************************************
  // receive side
  // ****************************************************************
  // bits taken on sclk rise, msb first; frame restarts on deselect
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bit_cnt    <= 3'h0;
      shift_in   <= 8'h00;
      data_phase <= 1'b0;
      cmd_valid  <= 1'b0;
      cmd_read   <= 1'b0;
      cmd_addr   <= 7'h00;
      wr_valid   <= 1'b0;
      wr_data    <= 8'h00;
    end else begin
      cmd_valid <= 1'b0;
      wr_valid  <= 1'b0;
      if (!active) begin
        bit_cnt    <= 3'h0;
        data_phase <= 1'b0;
      end else if (rise) begin
        shift_in <= next_byte;
        bit_cnt  <= bit_cnt + 3'h1;
        if (bit_cnt == sense_regs_pkg::LAST_BIT) begin
          data_phase <= 1'b1;
          if (!data_phase) begin
            cmd_valid <= 1'b1;
            cmd_read  <= next_byte[sense_regs_pkg::CMD_READ_BIT];
            cmd_addr  <= next_byte[6:0];
          end else if (!cmd_read) begin
            wr_valid <= 1'b1;
            wr_data  <= next_byte;
          end
        end
      end
    end
  end

  // ****************************************************************
  // transmit side
  // ****************************************************************
  // read byte loaded on first fall of data phase, shifted on later falls
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      shift_out <= 8'h00;
    end else if (fall && data_phase && cmd_read) begin
      if (bit_cnt == 3'h0) begin
        shift_out <= rd_data;
      end else begin
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

  // drive only while selected
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo    <= shift_out[7];
      sdo_oe <= active;
    end
  end
endmodule
`default_nettype wire

// ---- dv/host_spi_model.sv ----
// host controller model: drives serial frames on the register port
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
  // clock
  input  wire logic mclk,
  // serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  // mclk cycles per serial half period, above the minimum of 6
  localparam int HALF = 8;

  // idle pins: clock low, not selected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // ************************************************
  // one frame: command byte, data byte, msb first
  // ************************************************
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] word;
    word  = {cmd, wdata};
    rdata = 8'h00;
    @(posedge mclk) cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge mclk) sdi <= word[i];
      repeat (HALF) @(posedge mclk);
      // answer bits are taken at the rising serial edge
      if (i < 8) rdata = {rdata[6:0], sdo};
      sclk <= 1'b1;
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b0;
    end
    // hold select until a write has landed
    repeat (2 * HALF) @(posedge mclk);
    cs_n <= 1'b1;
    sdi  <= ~sdi; // released line: not the last value
    repeat (HALF) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ---- dv/inductive_sensor_status_regs_props.sv ----
// assertions on the ports of the sensor register bank
`timescale 1ns/1ps
`default_nettype none
module inductive_sensor_status_regs_props #(
  parameter logic [7:0] CEILING_RESET = 8'h00
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // serial select and driver enable
  input  wire logic        cs_n,
  input  wire logic        sdo_oe,
  // event pin and front end strobe
  input  wire logic        event_pin_n,
  input  wire logic        conv_valid,
  // front end controls
  input  wire logic        conversion_enable,
  input  wire logic [11:0] sample_divide,
  input  wire logic [1:0]  amplitude_select,
  input  wire logic [7:0]  loss_range_floor,
  input  wire logic [7:0]  loss_range_ceiling
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ************************************************
  // sequences and properties
  // ************************************************
  // host has left the port deselected
  sequence link_idle;
    cs_n [*5];
  endsequence
  // neither a frame nor a conversion arriving
  sequence no_cause;
    (cs_n && !conv_valid) [*4];
  endsequence

  a_reset_state: assert property (disable iff (1'b0)
    reset && $past(reset) |-> !conversion_enable && event_pin_n && !sdo_oe &&
      loss_range_floor == 8'h14 && loss_range_ceiling == CEILING_RESET)
    else $error("reset state wrong");
  a_divide_legal: assert property (
    sample_divide inside {12'h040, 12'h080, 12'h100, 12'h200,
      12'h400, 12'h800})
    else $error("sample divide outside the code set");
  a_config_written: assert property (
    $changed(sample_divide) || $changed(amplitude_select) |->
      !$past(cs_n, 3))
    else $error("configuration moved without a write");
  a_power_written: assert property (
    $changed(conversion_enable) |-> !$past(cs_n, 3))
    else $error("conversion enable moved without a write");
  a_range_hold: assert property (
    link_idle |-> $stable(loss_range_floor) &&
      $stable(loss_range_ceiling))
    else $error("range limits moved while idle");
  a_pin_quiet: assert property (
    no_cause |=> $stable(event_pin_n))
    else $error("event pin moved without a cause");
  a_oe_idle: assert property (
    link_idle |-> !sdo_oe)
    else $error("data out driven while deselected");
  a_oe_frame: assert property (
    (!cs_n) [*5] |-> sdo_oe)
    else $error("data out not driven while selected");
endmodule

bind inductive_sensor_status_regs inductive_sensor_status_regs_props #(
  .CEILING_RESET(CEILING_RESET)
) props (
  .mclk(mclk),
  .reset(reset),
  .cs_n(cs_n),
  .sdo_oe(sdo_oe),
  .event_pin_n(event_pin_n),
  .conv_valid(conv_valid),
  .conversion_enable(conversion_enable),
  .sample_divide(sample_divide),
  .amplitude_select(amplitude_select),
  .loss_range_floor(loss_range_floor),
  .loss_range_ceiling(loss_range_ceiling)
);
`default_nettype wire

// ---- dv/inductive_sensor_status_regs_tb_top.sv ----
// self-checking bench for the inductive sensor register bank
`timescale 1ns/1ps
`default_nettype none
module inductive_sensor_status_regs_tb_top;
  logic        mclk, reset, sclk, cs_n, sdi, sdo, sdo_oe, event_pin_n;
  logic        conv_valid, conv_below_floor, conv_above_ceiling;
  logic        osc_stopped, conversion_enable;
  logic [7:0]  conv_loss, loss_range_floor, loss_range_ceiling, rd;
  logic [23:0] conv_freq;
  logic [11:0] sample_divide;
  logic [1:0]  amplitude_select;
  int          mismatches;
  int          total_checks;

  // design and host model
  inductive_sensor_status_regs uut (
    .mclk(mclk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .event_pin_n(event_pin_n),
    .conv_valid(conv_valid), .conv_loss(conv_loss),
    .conv_below_floor(conv_below_floor),
    .conv_above_ceiling(conv_above_ceiling), .conv_freq(conv_freq),
    .osc_stopped(osc_stopped), .conversion_enable(conversion_enable),
    .sample_divide(sample_divide), .amplitude_select(amplitude_select),
    .loss_range_floor(loss_range_floor),
    .loss_range_ceiling(loss_range_ceiling)
  );
  host_spi_model host (
    .mclk(mclk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo)
  );

  // clock: 4 ns period
  always #2 mclk = ~mclk;

  // ************************************************
  // access and compare tasks
  // ************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
    host.xfer({1'b0, addr}, data, rd);
  endtask
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] exp);
    host.xfer({1'b1, addr}, 8'h00, rd);
    check(rd, exp);
  endtask
  task automatic convert(input logic [7:0] loss, input logic [23:0] freq,
                         input logic below, input logic above);
    @(posedge mclk);
    {conv_valid, conv_loss, conv_freq} <= {1'b1, loss, freq};
    {conv_below_floor, conv_above_ceiling} <= {below, above};
    @(posedge mclk) conv_valid <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end

  // main sequence
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    mismatches = 0;
    total_checks = 0;
    {conv_valid, conv_below_floor, conv_above_ceiling, osc_stopped} = 4'h0;
    conv_loss = 8'h00;
    conv_freq = 24'h00_0000;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    read_reg(sense_regs_pkg::ADDR_FLOOR, 8'h14);
    read_reg(sense_regs_pkg::ADDR_CEILING, 8'h00);
    read_reg(sense_regs_pkg::ADDR_CONFIG, 8'h1b);
    read_reg(sense_regs_pkg::ADDR_THR_HIGH, 8'hff);
    read_reg(sense_regs_pkg::ADDR_THR_LOW, 8'h00);
    read_reg(sense_regs_pkg::ADDR_PIN_FUNC, 8'h00);
    read_reg(sense_regs_pkg::ADDR_POWER, 8'h00);
    check(conversion_enable, 1'b0);
    check(sample_divide, 12'h080);
    check(amplitude_select, 2'h3);
    read_reg(7'h03, 8'h00);
    write_reg(sense_regs_pkg::ADDR_STATUS, 8'hff);
    read_reg(sense_regs_pkg::ADDR_STATUS, 8'h60);
    write_reg(sense_regs_pkg::ADDR_FLOOR, 8'h3b);
    write_reg(sense_regs_pkg::ADDR_CEILING, 8'h12);
    check({loss_range_floor, loss_range_ceiling}, 16'h3b12);
    for (int c = 2; c < 8; c++) begin
      write_reg(sense_regs_pkg::ADDR_CONFIG, 8'(c));
      check(sample_divide, 12'h040 << (c - 2));
    end
    check(amplitude_select, 2'h0);
    write_reg(sense_regs_pkg::ADDR_POWER, 8'h01);
    check(conversion_enable, 1'b1);
    write_reg(sense_regs_pkg::ADDR_THR_HIGH, 8'h80);
    write_reg(sense_regs_pkg::ADDR_THR_LOW, 8'h40);
    write_reg(sense_regs_pkg::ADDR_PIN_FUNC, 8'h02);
    convert(8'h20, 24'h00_0001, 1'b0, 1'b0);
    check(event_pin_n, 1'b1);
    read_reg(sense_regs_pkg::ADDR_STATUS, 8'h30);
    convert(8'h60, 24'h00_0002, 1'b0, 1'b0);
    check(event_pin_n, 1'b1);
    convert(8'h90, 24'h00_0003, 1'b0, 1'b0);
    check(event_pin_n, 1'b0);
    convert(8'h60, 24'h00_0004, 1'b0, 1'b0);
    check(event_pin_n, 1'b0);
    convert(8'h55, 24'h12_3456, 1'b0, 1'b0);
    read_reg(sense_regs_pkg::ADDR_LOSS, 8'h55);
    read_reg(sense_regs_pkg::ADDR_FREQ_LOW, 8'h56);
    read_reg(sense_regs_pkg::ADDR_FREQ_MID, 8'h34);
    read_reg(sense_regs_pkg::ADDR_FREQ_HIGH, 8'h12);
    convert(8'h66, 24'h65_4321, 1'b0, 1'b0);
    read_reg(sense_regs_pkg::ADDR_FREQ_LOW, 8'h56);
    read_reg(sense_regs_pkg::ADDR_STATUS, 8'h20);
    read_reg(sense_regs_pkg::ADDR_LOSS, 8'h66);
    read_reg(sense_regs_pkg::ADDR_FREQ_HIGH, 8'h65);
    read_reg(sense_regs_pkg::ADDR_STATUS, 8'h60);
    convert(8'h77, 24'h00_0005, 1'b1, 1'b0);
    read_reg(sense_regs_pkg::ADDR_LOSS, 8'h00);
    convert(8'h77, 24'h00_0006, 1'b0, 1'b1);
    read_reg(sense_regs_pkg::ADDR_LOSS, 8'hff);
    convert(8'h77, 24'h00_0007, 1'b1, 1'b1);
    read_reg(sense_regs_pkg::ADDR_LOSS, 8'h00);
    @(posedge mclk) osc_stopped <= 1'b1;
    read_reg(sense_regs_pkg::ADDR_STATUS, 8'hf0);
    @(posedge mclk) osc_stopped <= 1'b0;
    write_reg(sense_regs_pkg::ADDR_PIN_FUNC, 8'h01);
    convert(8'h90, 24'h00_0008, 1'b0, 1'b0);
    check(event_pin_n, 1'b0);
    read_reg(sense_regs_pkg::ADDR_STATUS, 8'h00);
    write_reg(sense_regs_pkg::ADDR_PIN_FUNC, 8'h04);
    check(event_pin_n, 1'b0);
    read_reg(sense_regs_pkg::ADDR_LOSS, 8'h90);
    check(event_pin_n, 1'b1);
    convert(8'h10, 24'h00_0009, 1'b0, 1'b0);
    check(event_pin_n, 1'b0);
    for (int c = 0; c < 4; c += 3) begin
      write_reg(sense_regs_pkg::ADDR_PIN_FUNC, 8'(c));
      check(event_pin_n, 1'b1);
    end
    write_reg(sense_regs_pkg::ADDR_POWER, 8'h00);
    read_reg(sense_regs_pkg::ADDR_LOSS, 8'h10);
    convert(8'h20, 24'h00_000a, 1'b0, 1'b0);
    read_reg(sense_regs_pkg::ADDR_STATUS, 8'h70);
    end_of_test();
  end
endmodule
`default_nettype wire
